// [asr_pkg.sv]
// constants shared by the sleep-state rail controller and its input filter
package asr_pkg;

    // ----------------------------------------------------------------
    // clock and timing
    // ----------------------------------------------------------------
    localparam int CLK_PERIOD_NS      = 20;
    localparam int DEGLITCH_NS        = 2000;   // pulses shorter than this are rejected
    localparam int SLEEP_DELAY_US     = 200;    // s3 request to sleep entry
    // least time, rounded up to whole cycles
    localparam int DEGLITCH_CYCLES    = (DEGLITCH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SLEEP_DELAY_CYCLES = (SLEEP_DELAY_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // ----------------------------------------------------------------
    // apb register map (byte addresses)
    // ----------------------------------------------------------------
    localparam logic [7:0] CTRL_OFFSET   = 8'h00;
    localparam logic [7:0] STATUS_OFFSET = 8'h04;

    // control register fields
    localparam int         CTRL_SHUTDOWN_BIT   = 0;  // software shutdown, like a grounded soft-start
    localparam int         CTRL_FAULT_EN_BIT   = 1;  // fault reporting on the shared pin
    localparam logic [1:0] CTRL_RESET          = 2'h2;

    // status register fields
    localparam int STAT_STATE_LSB   = 0;   // 3-bit state code
    localparam int STAT_CFG33_BIT   = 4;
    localparam int STAT_CFG5_BIT    = 5;
    localparam int STAT_MEMSEL_BIT  = 6;   // 1 selects the 3.3V memory setting
    localparam int STAT_FAULT_BIT   = 7;
    localparam int STAT_SOURCE_LSB  = 8;   // 9 fault sources, uv then overtemp

    // ----------------------------------------------------------------
    // operating states
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_OFF,      // por or shutdown, everything off
        ST_ACTIVE,   // s0, s1/s2
        ST_WAIT,     // sleep entry delay running, outputs still active
        ST_S3,
        ST_S45
    } asr_state_type;

endpackage : asr_pkg

// [asr_deglitch.sv]
// two-flop synchroniser followed by a stability filter for one sleep request pin
`timescale 1ns/1ps
module asr_deglitch
    import asr_pkg::*;
#(
    parameter int          FILTER_CYCLES = DEGLITCH_CYCLES,
    parameter logic        INIT_LEVEL    = 1'b1
) (
    input  wire logic pclk,      // system clock
    input  wire logic presetn,   // async reset, active low
    input  wire logic pin_in,    // raw pin level
    output logic      level_out  // filtered level
);

    localparam int CW = $clog2(FILTER_CYCLES + 1);
    localparam logic [CW-1:0] LAST = CW'(FILTER_CYCLES - 1);

    logic          meta_reg;
    logic          sync_reg;
    logic [CW-1:0] cnt_reg;

    // ----------------------------------------------------------------
    // synchroniser: only sync_reg reads meta_reg
    // ----------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta_reg <= INIT_LEVEL;
            sync_reg <= INIT_LEVEL;
        end else begin
            meta_reg <= pin_in;
            sync_reg <= meta_reg;
        end
    end

    // the new level must stand unbroken for the full window before it passes
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_reg   <= '0;
            level_out <= INIT_LEVEL;
        end else if (sync_reg == level_out) begin
            cnt_reg <= '0;
        end else if (cnt_reg == LAST) begin
            cnt_reg   <= '0;
            level_out <= sync_reg;
        end else begin
            cnt_reg <= cnt_reg + CW'(1);
        end
    end

    property p_filter_window;
        @(posedge pclk) disable iff (!presetn)
        (level_out != $past(level_out)) |-> ($past(cnt_reg) == LAST);
    endproperty
    a_filter_window: assert property (p_filter_window) else $error("filtered level moved early");

endmodule : asr_deglitch

// [asr_rail_ctrl.sv]
// sleep-state decoder, rail enable logic, fault pin and apb status block
//
// Local design decisions: the placing of the registers and register access over APB.
`timescale 1ns/1ps

module asr_rail_ctrl
    import asr_pkg::*;
#(
    parameter int SLEEP_DELAY = SLEEP_DELAY_CYCLES,   // cycles from s3 request to sleep
    parameter int FILTER_LEN  = DEGLITCH_CYCLES       // cycles of request filter
) (
    input  wire logic        pclk,                   // 50 MHz clock
    input  wire logic        presetn,                // async reset, active low
    input  wire logic        psel,                   // apb select
    input  wire logic        penable,                // apb access phase
    input  wire logic        pwrite,                 // apb write
    input  wire logic [7:0]  paddr,                  // apb byte address
    input  wire logic [31:0] pwdata,                 // apb write data
    output logic [31:0]      prdata,                 // apb read data
    output logic             pready,                 // apb ready
    output logic             pslverr,                // apb error on unmapped address
    input  wire logic        sleep_s3_request_n,     // s3 request, active low
    input  wire logic        sleep_s5_request_n,     // s5 request, active low
    input  wire logic        dual33_sleep_config,    // 1: 3.3V dual off in s4/s5
    input  wire logic        dual5_sleep_config,     // 1: 5V dual kept in sleep
    input  wire logic        standby5_bias_input,    // standby bias above por level
    input  wire logic        soft_start_low,         // soft-start node pulled low
    input  wire logic        memory_output_sense,    // memory output undervoltage
    input  wire logic        dual33_output_sense,    // 3.3V dual undervoltage
    input  wire logic        dual5_output_sense,     // 5V dual undervoltage
    input  wire logic        standby33_sense,        // 3.3V standby undervoltage
    input  wire logic        clock_supply_sense,     // clock supply undervoltage
    input  wire logic        main33_uv,              // main 3.3V undervoltage
    input  wire logic        main5_uv,               // main 5V undervoltage
    input  wire logic        main12_uv,              // main 12V undervoltage
    input  wire logic        overtemp,               // overtemperature
    input  wire logic        fault_memsel_pin_in,    // shared pin level read back
    output logic             fault_memsel_pin_out,   // shared pin drive level
    output logic             fault_memsel_pin_oe,    // shared pin drive enable
    output logic             memory_select_33,       // memory setting, 1 = 3.3V
    output logic             memory_pass_drive,      // external memory pass element
    output logic             memory_internal_enable, // internal memory pass element
    output logic             dual33_standby_drive,   // 3.3V dual standby regulation
    output logic             dual_active_gate_drive, // main supplies onto dual planes
    output logic             dual5_standby_switch,   // standby 5V onto 5V dual
    output logic             standby33_output,       // 3.3V standby regulator enable
    output logic             clock_supply_output     // 2.5V clock regulator enable
);

    localparam int TW = $clog2(SLEEP_DELAY + 1);
    localparam logic [TW-1:0] T_LAST = TW'(SLEEP_DELAY - 1);
    localparam int NMON = 9;

    // ----------------------------------------------------------------
    // input synchronisers and request filters
    // ----------------------------------------------------------------
    logic [NMON+4:0] meta_reg;
    logic [NMON+4:0] sync_reg;
    logic            s3_n;
    logic            s5_n;

    // monitors, bias, shutdown, configs and the shared pin pass two flops
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta_reg <= '0;
            sync_reg <= '0;
        end else begin
            meta_reg <= {fault_memsel_pin_in, dual5_sleep_config, dual33_sleep_config,
                         soft_start_low, standby5_bias_input, overtemp, main12_uv, main5_uv,
                         main33_uv, clock_supply_sense, standby33_sense, dual5_output_sense,
                         dual33_output_sense, memory_output_sense};
            sync_reg <= meta_reg;
        end
    end

    wire logic [NMON-1:0] mon_uv   = sync_reg[NMON-1:0];
    wire logic            bias_ok  = sync_reg[NMON];
    wire logic            ss_low   = sync_reg[NMON+1];
    wire logic            cfg33_in = sync_reg[NMON+2];
    wire logic            cfg5_in  = sync_reg[NMON+3];
    wire logic            pin_in   = sync_reg[NMON+4];

    asr_deglitch #(.FILTER_CYCLES(FILTER_LEN), .INIT_LEVEL(1'b1)) u_s3_filter (
        .pclk      (pclk),
        .presetn   (presetn),
        .pin_in    (sleep_s3_request_n),
        .level_out (s3_n)
    );

    asr_deglitch #(.FILTER_CYCLES(FILTER_LEN), .INIT_LEVEL(1'b1)) u_s5_filter (
        .pclk      (pclk),
        .presetn   (presetn),
        .pin_in    (sleep_s5_request_n),
        .level_out (s5_n)
    );

    // ----------------------------------------------------------------
    // control register and power gating
    // ----------------------------------------------------------------
    logic [1:0] ctrl_reg;
    logic       por_n;
    logic       run;

    assign por_n = bias_ok;
    assign run   = por_n && !ss_low && !ctrl_reg[CTRL_SHUTDOWN_BIT];

    // ----------------------------------------------------------------
    // sleep state machine
    // ----------------------------------------------------------------
    asr_state_type state_reg;
    asr_state_type state_next;
    logic [TW-1:0] timer_reg;
    logic          capture;

    // illegal requests simply leave the current state in place
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            ST_OFF: begin
                if (s3_n)
                    state_next = ST_ACTIVE;
                else if (!s5_n)
                    state_next = ST_S45;
                else
                    state_next = ST_S3;
            end
            ST_ACTIVE: begin
                if (!s3_n)
                    state_next = ST_WAIT;
            end
            ST_WAIT: begin
                if (s3_n)
                    state_next = ST_ACTIVE;
                else if (timer_reg == T_LAST)
                    state_next = s5_n ? ST_S3 : ST_S45;
            end
            ST_S3: begin
                if (s3_n && s5_n)
                    state_next = ST_ACTIVE;
            end
            ST_S45: begin
                if (s3_n && s5_n)
                    state_next = ST_ACTIVE;
            end
            default: state_next = ST_OFF;
        endcase
    end

    // configs are taken on the way into sleep or when leaving off
    assign capture = (state_reg == ST_OFF) ||
                     ((state_next == ST_S3 || state_next == ST_S45) && state_reg != state_next);

    // por, shutdown and software shutdown all park the machine in off
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= ST_OFF;
        end else if (!run) begin
            state_reg <= ST_OFF;
        end else begin
            state_reg <= state_next;
        end
    end

    // delay timer only runs while waiting for sleep entry
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            timer_reg <= '0;
        end else if (state_reg == ST_WAIT && run) begin
            timer_reg <= timer_reg + TW'(1);
        end else begin
            timer_reg <= '0;
        end
    end

    // ----------------------------------------------------------------
    // latched configuration and memory select
    // ----------------------------------------------------------------
    logic cfg33_reg;
    logic cfg5_reg;
    logic memsel_reg;

    // in sleep the latched copy wins, so late pin changes are ignored
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg33_reg  <= 1'b0;
            cfg5_reg   <= 1'b1;
            memsel_reg <= 1'b0;
        end else if (run && capture) begin
            cfg33_reg <= cfg33_in;
            cfg5_reg  <= cfg5_in;
            if (state_reg == ST_OFF)
                memsel_reg <= pin_in;
        end
    end

    // ----------------------------------------------------------------
    // rail enables, registered from state and run; standby 3.3V from run alone
    // ----------------------------------------------------------------
    wire logic is_active = (state_reg == ST_ACTIVE) || (state_reg == ST_WAIT);
    wire logic is_s3     = (state_reg == ST_S3);
    wire logic is_sleep  = is_s3 || (state_reg == ST_S45);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            memory_pass_drive      <= 1'b0;
            memory_internal_enable <= 1'b0;
            dual33_standby_drive   <= 1'b0;
            dual_active_gate_drive <= 1'b0;
            dual5_standby_switch   <= 1'b0;
            standby33_output       <= 1'b0;
            clock_supply_output    <= 1'b0;
            memory_select_33       <= 1'b0;
        end else begin
            memory_pass_drive      <= run && is_active;
            memory_internal_enable <= run && is_s3;
            dual33_standby_drive   <= run && is_sleep && (is_s3 || !cfg33_reg);
            dual_active_gate_drive <= run && is_active;
            dual5_standby_switch   <= run && is_sleep && cfg5_reg;
            standby33_output       <= por_n && !ss_low && !ctrl_reg[CTRL_SHUTDOWN_BIT];
            clock_supply_output    <= run && is_active;
            memory_select_33       <= memsel_reg;
        end
    end

    // ----------------------------------------------------------------
    // fault detection and shared pin
    // ----------------------------------------------------------------
    logic [NMON-1:0] armed;
    logic            fault;

    // an output is only watched while it is meant to be up
    assign armed = {1'b1,
                    {3{is_active}},                                  // main supplies
                    clock_supply_output,
                    standby33_output,
                    dual_active_gate_drive || dual5_standby_switch,
                    dual_active_gate_drive || dual33_standby_drive,
                    memory_pass_drive || memory_internal_enable};
    assign fault = |(mon_uv & armed);

    // shutdown forces the pin low; otherwise it is driven high on an enabled fault, else released for sensing
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fault_memsel_pin_out <= 1'b0;
            fault_memsel_pin_oe  <= 1'b0;
        end else if (por_n && !run) begin
            fault_memsel_pin_out <= 1'b0;
            fault_memsel_pin_oe  <= 1'b1;
        end else begin
            fault_memsel_pin_out <= run && fault && ctrl_reg[CTRL_FAULT_EN_BIT];
            fault_memsel_pin_oe  <= run && fault && ctrl_reg[CTRL_FAULT_EN_BIT];
        end
    end

    // ----------------------------------------------------------------
    // apb slave: one wait state, error on unmapped address
    // ----------------------------------------------------------------
    wire logic hit_ctrl = (paddr == CTRL_OFFSET);
    wire logic hit_stat = (paddr == STATUS_OFFSET);
    wire logic access   = psel && penable && !pready;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= '0;
        end else begin
            pready  <= access;
            pslverr <= access && (!(hit_ctrl || hit_stat) || (hit_stat && pwrite)); // status is read-only
            if (access && !pwrite && hit_ctrl)
                prdata <= {30'h0, ctrl_reg};
            else if (access && !pwrite && hit_stat)
                prdata <= {15'h0, mon_uv, fault, memsel_reg, cfg5_reg, cfg33_reg, 1'b0, state_reg};
            else
                prdata <= '0;
        end
    end

    // write lands at the edge that completes the access
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_reg <= CTRL_RESET;
        end else if (psel && penable && pready && pwrite && hit_ctrl) begin
            ctrl_reg <= pwdata[1:0];
        end
    end

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    property p_no_s3_to_s45;
        (state_reg == ST_S3) |=> (state_reg != ST_S45);
    endproperty
    a_no_s3_to_s45: assert property (p_no_s3_to_s45) else $error("s3 moved to s4/s5");

    property p_no_s45_to_s3;
        (state_reg == ST_S45) |=> (state_reg != ST_S3);
    endproperty
    a_no_s45_to_s3: assert property (p_no_s45_to_s3) else $error("s4/s5 moved to s3");

    property p_delay_expiry;
        (run && state_reg == ST_WAIT && timer_reg == T_LAST && !s3_n)
            |=> (state_reg == ($past(s5_n) ? ST_S3 : ST_S45)) ##1 !dual_active_gate_drive;
    endproperty
    a_delay_expiry: assert property (p_delay_expiry) else $error("sleep entry wrong after delay");

    property p_shutdown;
        (por_n && ss_low) |=> (fault_memsel_pin_oe && !fault_memsel_pin_out && !memory_pass_drive
                               && !dual5_standby_switch && !standby33_output);
    endproperty
    a_shutdown: assert property (p_shutdown) else $error("shutdown did not clear outputs");

    property p_por_off;
        !por_n |=> (state_reg == ST_OFF) && !clock_supply_output && !standby33_output;
    endproperty
    a_por_off: assert property (p_por_off) else $error("outputs alive during por");

    property p_gate_active;
        dual_active_gate_drive |-> $past(state_reg == ST_ACTIVE || state_reg == ST_WAIT);
    endproperty
    a_gate_active: assert property (p_gate_active) else $error("gate drive outside active");

    property p_clock_active;
        clock_supply_output |-> !$past(is_sleep) && !dual5_standby_switch;
    endproperty
    a_clock_active: assert property (p_clock_active) else $error("clock regulator on in sleep");

    property p_dual5_sleep;
        (run && is_sleep) ##1 run |-> (dual5_standby_switch == $past(cfg5_reg));
    endproperty
    a_dual5_sleep: assert property (p_dual5_sleep) else $error("5V dual standby switch wrong");

    property p_cfg_hold;
        (is_sleep && $past(is_sleep)) |-> $stable(cfg33_reg) && $stable(cfg5_reg);
    endproperty
    a_cfg_hold: assert property (p_cfg_hold) else $error("config changed while asleep");

    c_enter_s3: cover property ((state_reg == ST_WAIT) ##1 (state_reg == ST_S3));
    c_enter_s45: cover property ((state_reg == ST_WAIT) ##1 (state_reg == ST_S45));
    c_wait_abort: cover property ((state_reg == ST_WAIT) ##1 (state_reg == ST_ACTIVE));
    c_fault_pin: cover property (fault_memsel_pin_oe && fault_memsel_pin_out);

endmodule : asr_rail_ctrl

// [asr_chipset_model.sv]
// chipset side model: sleep request pins and dual-plane config straps
`timescale 1ns/1ps
module asr_chipset_model (
    input  wire logic pclk,               // system clock
    input  wire logic goal_s3_n,          // wanted s3 level
    input  wire logic goal_s5_n,          // wanted s5 level
    input  wire logic goal_cfg33,         // wanted 3.3V dual config
    input  wire logic goal_cfg5,          // wanted 5V dual config
    output logic      s3_n  = 1'b1,       // s3 request pin
    output logic      s5_n  = 1'b1,       // s5 request pin
    output logic      cfg33 = 1'b0,       // 3.3V dual config pin
    output logic      cfg5  = 1'b0        // 5V dual config pin
);
    // pins move just after the edge, as the chipset's own flops do
    always @(posedge pclk) begin
        s3_n <= goal_s3_n;
        s5_n <= goal_s5_n;
    end
    // configs only follow while awake; a change asked during sleep waits
    always @(posedge pclk) begin
        if (s3_n && s5_n) begin
            cfg33 <= goal_cfg33;
            cfg5  <= goal_cfg5;
        end
    end
endmodule : asr_chipset_model

// [tb_top.sv]
// self-checking bench for the sleep-state rail controller
`timescale 1ns/1ps
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin fails++; $display("unexpected %s exp %h got %h", n, e, g); end end
module tb_top;
    import asr_pkg::*;
    logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic        pready, pslverr, er, g3 = 1, g5 = 1, gc33 = 0, gc5 = 0;
    logic        s3_n, s5_n, c33, c5, bias = 1, ss = 0, strap = 1, pin_out, pin_oe;
    logic [8:0]  mon = 9'h000;
    logic [6:0]  en;
    logic        msel, pin;
    int          fails = 0, comparisons = 0;
    // shared pin: device drive wins, else the select strap is read back
    assign pin = pin_oe ? pin_out : strap;
    initial forever #10 pclk = ~pclk;
    asr_chipset_model asr_chipset_model_i (.pclk(pclk), .goal_s3_n(g3), .goal_s5_n(g5), .goal_cfg33(gc33),
        .goal_cfg5(gc5), .s3_n(s3_n), .s5_n(s5_n), .cfg33(c33), .cfg5(c5));
    asr_rail_ctrl #(.SLEEP_DELAY(20), .FILTER_LEN(4)) asr_rail_ctrl_i (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .sleep_s3_request_n(s3_n), .sleep_s5_request_n(s5_n),
        .dual33_sleep_config(c33), .dual5_sleep_config(c5), .standby5_bias_input(bias), .soft_start_low(ss),
        .memory_output_sense(mon[0]), .dual33_output_sense(mon[1]), .dual5_output_sense(mon[2]),
        .standby33_sense(mon[3]), .clock_supply_sense(mon[4]), .main33_uv(mon[5]), .main5_uv(mon[6]),
        .main12_uv(mon[7]), .overtemp(mon[8]), .fault_memsel_pin_in(pin), .fault_memsel_pin_out(pin_out),
        .fault_memsel_pin_oe(pin_oe), .memory_select_33(msel), .memory_pass_drive(en[6]),
        .memory_internal_enable(en[5]), .dual33_standby_drive(en[4]), .dual_active_gate_drive(en[3]),
        .dual5_standby_switch(en[2]), .standby33_output(en[1]), .clock_supply_output(en[0]));
    task summarize;
        $display("checks %0d mismatches %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : summarize
    // one apb transfer; request held until pready is seen at an edge
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 20) begin
            fails++;
            summarize();
        end
    endtask : apb
    // poll the state code; the limit stands in for a hang
    task wait_state(input logic [2:0] s);
        for (int i = 0; i < 100; i++) begin
            apb(0, STATUS_OFFSET, 0);
            if (rd[2:0] === s) break;
        end
        `CHK("state", s, rd[2:0])
        repeat (3) @(posedge pclk);
    endtask : wait_state
    initial begin
        repeat (8) @(posedge pclk);
        `CHK("reset enables", 7'h00, en)
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        wait_state(3'd1);
        `CHK("active enables", 7'h4b, en)
        `CHK("memory select", 1'b1, msel)
        apb(0, CTRL_OFFSET, 0);
        `CHK("ctrl reset", {30'h0, CTRL_RESET}, rd)
        apb(1, STATUS_OFFSET, 1);
        `CHK("status write error", 1'b1, er)
        apb(0, 8'h40, 0);
        `CHK("unmapped error", 1'b1, er)
        $display("test registers done");
        // a two-cycle dip on s3 must not leave active
        g3 <= 1'b0;
        repeat (2) @(posedge pclk);
        g3 <= 1'b1;
        repeat (40) @(posedge pclk);
        apb(0, STATUS_OFFSET, 0);
        `CHK("glitch state", 3'd1, rd[2:0])
        // faults from memory sense, main 3.3V and temperature
        for (int k = 0; k < 3; k++) begin
            mon[k == 0 ? 0 : (k == 1 ? 5 : 8)] <= 1'b1;
            repeat (6) @(posedge pclk);
            `CHK("fault pin", 2'h3, {pin_oe, pin_out})
            mon <= 9'h000;
            repeat (6) @(posedge pclk);
        end
        $display("test faults done");
        {gc33, gc5, g3} <= 3'b010;
        wait_state(3'd3);
        `CHK("s3 enables", 7'h36, en)
        g5 <= 1'b0;
        repeat (40) @(posedge pclk);
        wait_state(3'd3);
        {g3, g5} <= 2'b11;
        wait_state(3'd1);
        {gc33, gc5} <= 2'b10;
        repeat (4) @(posedge pclk);
        {g3, g5} <= 2'b00;
        wait_state(3'd4);
        `CHK("s45 enables", 7'h02, en)
        {g3, g5} <= 2'b11;
        wait_state(3'd1);
        $display("test sleep states done");
        ss <= 1'b1;
        wait_state(3'd0);
        `CHK("shutdown enables", 7'h00, en)
        `CHK("shutdown pin", 2'h2, {pin_oe, pin_out})
        ss <= 1'b0;
        wait_state(3'd1);
        $display("test shutdown done");
        summarize();
    end
endmodule : tb_top
